// [hw/voice_port_pkg.sv]
package voice_port_pkg;
  // Frame layout: address bits first, then control bits, LSB first
  localparam int ADDR_BITS = 11;
  localparam int CTRL_BITS = 5;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  // Storage geometry
  localparam logic [10:0] ROW_COUNT = 11'h4B0;
  localparam logic [10:0] ROW_LAST = 11'h4AF;
  localparam int CELLS_PER_ROW = 1600;
  // Control field positions
  localparam int CUE_POS = 0;
  localparam int SKIP_POS = 1;
  localparam int POWER_POS = 2;
  localparam int PLAY_POS = 3;
  localparam int RUN_POS = 4;
  // Status word positions (shifted out LSB first)
  localparam int STAT_FULL_POS = 0;
  localparam int STAT_MARK_POS = 1;
  localparam int STAT_PTR_POS = 2;
  // Reset values
  localparam logic [10:0] ROW_RESET = 11'h000;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // External sample clock divider ratio
  localparam int EXT_DIV = 2;
endpackage

// [hw/voice_recorder_serial_command_port.sv]
// Operation
// - External sample clock is divided by two on entry.
// - Device is slave only; host makes the serial clock.
// - Sample input on rising serial edge, change output on falling edge.
// - A falling select edge starts a new instruction frame.
// - Instruction and status bits both travel least significant bit first.
// - Frame is 11 row address bits then 5 control bits.
// - Received instruction acts only after select returns high.
// - Interrupt raised when operation ends on end-of-message or memory end.
// - Pending interrupt clears when the next transfer begins.
// - Status shifts out while the new instruction shifts in.
// - Run bit set with power set starts an operation; run or power cleared ends it.
// - Storage has 1,200 rows of 1,600 cells.
// - Read-only status register and interrupt output for handshaking.
// - Control bits: cue, skip address, power, play/record, run.
// - Decode wake, play, record, cue, halt and halt-sleep patterns.
// - Open-drain interrupt pulled low on full, or on end-of-message outside record, until cleared.
// - Status carries memory-full flag, end-of-message flag, 11-bit row pointer.
`timescale 1ns/1ps
`default_nettype none
module voice_recorder_serial_command_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ext_sample_clock_in_i,
  input wire logic row_end_i,
  input wire logic end_of_message_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  output logic [10:0] row_pointer_out_o,
  output logic end_of_message_flag_o,
  output logic memory_full_flag_o,
  output logic powered_o,
  output logic running_o,
  output logic play_mode_o,
  output logic cue_mode_o,
  output logic sample_tick_o
);

  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    PLAY_ST = 2'b01,
    RECORD_ST = 2'b11,
    CUE_ST = 2'b10
  } op_state_t;

  // Two-stage synchronisers for the pins; only stage two is looked at
  logic [1:0] sclk_sync;
  logic [1:0] ss_sync;
  logic [1:0] mosi_sync;
  logic [1:0] ext_sync;
  logic sclk_d;
  logic ss_d;
  logic ext_d;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_sync <= 2'h0;
      ss_sync <= 2'h3;
      mosi_sync <= 2'h0;
      ext_sync <= 2'h0;
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
      ext_d <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk_i};
      ss_sync <= {ss_sync[0], ss_n_i};
      mosi_sync <= {mosi_sync[0], mosi_i};
      ext_sync <= {ext_sync[0], ext_sample_clock_in_i};
      sclk_d <= sclk_sync[1];
      ss_d <= ss_sync[1];
      ext_d <= ext_sync[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  logic ext_rise;
  assign sclk_rise = sclk_sync[1] & ~sclk_d;
  assign sclk_fall = ~sclk_sync[1] & sclk_d;
  assign ss_fall = ~ss_sync[1] & ss_d;
  assign ss_rise = ss_sync[1] & ~ss_d;
  assign ext_rise = ext_sync[1] & ~ext_d;

  // Divide the external clock by two: only rising edges count, so duty is moot
  logic ext_half;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_half <= 1'b0;
    end else if (ext_rise) begin
      ext_half <= ~ext_half;
    end
  end
  assign sample_tick_o = ext_rise & ext_half;

  // Receive shifter and bit counter
  logic [15:0] rx_shift;
  logic [4:0] bit_count;
  logic frame_full;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_shift <= 16'h0000;
      bit_count <= 5'h00;
      frame_full <= 1'b0;
    end else if (ss_fall) begin
      bit_count <= 5'h00;
      frame_full <= 1'b0;
    end else if (!ss_sync[1] && sclk_rise && !frame_full) begin
      rx_shift <= {mosi_sync[1], rx_shift[15:1]};
      if (bit_count == voice_port_pkg::FRAME_LAST) begin
        frame_full <= 1'b1;
      end
      bit_count <= bit_count + 5'h01;
    end
  end

  // Split the word: low 11 bits address, upper 5 control
  logic [10:0] rx_addr;
  logic [4:0] rx_ctrl;
  assign rx_addr = rx_shift[voice_port_pkg::ADDR_BITS-1:0];
  assign rx_ctrl = rx_shift[voice_port_pkg::FRAME_BITS-1:voice_port_pkg::ADDR_BITS];

  // Instruction executes only on select release after a full frame
  logic exec;
  assign exec = ss_rise & frame_full;

  logic [4:0] ctrl;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= voice_port_pkg::CTRL_RESET;
    end else if (exec) begin
      ctrl <= rx_ctrl;
    end
  end

  // Operation state machine
  op_state_t op_state;
  logic op_end;
  logic ptr_wrap;
  assign ptr_wrap = row_end_i && (row_pointer_out_o == voice_port_pkg::ROW_LAST);
  assign op_end = (op_state != IDLE_ST) &&
                  (ptr_wrap || (end_of_message_i && op_state != RECORD_ST));
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_state <= IDLE_ST;
    end else if (exec) begin
      // Run set starts; run clear or power clear stops
      if (!rx_ctrl[voice_port_pkg::RUN_POS] || !rx_ctrl[voice_port_pkg::POWER_POS]) begin
        op_state <= IDLE_ST;
      end else if (!rx_ctrl[voice_port_pkg::PLAY_POS]) begin
        op_state <= RECORD_ST;
      end else if (rx_ctrl[voice_port_pkg::CUE_POS]) begin
        op_state <= CUE_ST;
      end else begin
        op_state <= PLAY_ST;
      end
    end else if (op_end) begin
      op_state <= IDLE_ST;
    end
  end

  // Row pointer: loaded when run set and skip bit clear, advances at row ends
  logic [10:0] row_ptr;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      row_ptr <= voice_port_pkg::ROW_RESET;
    end else if (exec && rx_ctrl[voice_port_pkg::RUN_POS] &&
                 !rx_ctrl[voice_port_pkg::SKIP_POS]) begin
      // Out-of-range address clamps to the last row rather than aliasing
      row_ptr <= (rx_addr > voice_port_pkg::ROW_LAST) ? voice_port_pkg::ROW_LAST : rx_addr;
    end else if (op_state != IDLE_ST && row_end_i && !ptr_wrap) begin
      row_ptr <= row_ptr + 11'h001;
    end
  end
  assign row_pointer_out_o = row_ptr;

  // Sticky flags: a set in the same cycle as a frame start wins over the clear
  logic full_flag;
  logic marker_flag;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      full_flag <= 1'b0;
      marker_flag <= 1'b0;
    end else begin
      if (op_end && ptr_wrap) begin
        full_flag <= 1'b1;
      end else if (ss_fall) begin
        full_flag <= 1'b0;
      end
      if (op_end && !ptr_wrap) begin
        marker_flag <= 1'b1;
      end else if (ss_fall) begin
        marker_flag <= 1'b0;
      end
    end
  end
  assign memory_full_flag_o = full_flag;
  assign end_of_message_flag_o = marker_flag;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = full_flag | marker_flag;

  // Transmit shifter: status captured at frame start, moves on falling edges
  logic [15:0] tx_shift;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_shift <= 16'h0000;
    end else if (ss_fall) begin
      tx_shift <= {3'h0, row_ptr, marker_flag, full_flag};
    end else if (!ss_sync[1] && sclk_fall && bit_count != 5'h00) begin
      tx_shift <= {1'b0, tx_shift[15:1]};
    end
  end
  assign miso_o = tx_shift[0];
  assign miso_oe_o = ~ss_sync[1];

  assign powered_o = ctrl[voice_port_pkg::POWER_POS];
  assign running_o = (op_state != IDLE_ST);
  assign play_mode_o = ctrl[voice_port_pkg::PLAY_POS];
  assign cue_mode_o = (op_state == CUE_ST);

endmodule
`default_nettype wire

// [testbench/voice_port_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module voice_port_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ss_n_i,
  input wire logic end_of_message_i,
  input wire logic miso_oe_o,
  input wire logic irq_n_oe_o,
  input wire logic [10:0] row_pointer_out_o,
  input wire logic end_of_message_flag_o,
  input wire logic memory_full_flag_o,
  input wire logic powered_o,
  input wire logic running_o,
  input wire logic play_mode_o,
  input wire logic sample_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Flags drive the shared interrupt line
  wire logic flag_any = end_of_message_flag_o | memory_full_flag_o;
  a_irq_follows_flags: assert property (flag_any |-> ##[0:2] irq_n_oe_o)
    else $error("irq");
  a_frame_clears_flags: assert property ($fell(ss_n_i) |-> ##[1:6] !flag_any)
    else $error("clr");
  a_miso_in_frame: assert property (!ss_n_i [*6] |-> miso_oe_o) else $error("oe on");
  a_miso_off_idle: assert property (ss_n_i [*6] |-> !miso_oe_o) else $error("oe off");
  a_pointer_in_array: assert property (row_pointer_out_o <= voice_port_pkg::ROW_LAST)
    else $error("ptr");
  a_hold_in_frame: assert property (!ss_n_i [*5] |->
    $stable(powered_o) && $stable(play_mode_o)) else $error("early");
  a_run_needs_power: assert property (running_o |-> powered_o) else $error("pwr");
  a_marker_ends_play: assert property (running_o && play_mode_o && end_of_message_i
    |-> ##[1:4] end_of_message_flag_o && !running_o) else $error("marker");
  a_tick_single: assert property (sample_tick_o |=> !sample_tick_o) else $error("tick");
  cover property ($rose(running_o));
  cover property ($rose(memory_full_flag_o));
  cover property ($rose(end_of_message_flag_o));
endmodule
bind voice_recorder_serial_command_port voice_port_monitor voice_port_monitor_i (
  .clk_i(clk_i), .reset_i(reset_i), .ss_n_i(ss_n_i), .end_of_message_i(end_of_message_i),
  .miso_oe_o(miso_oe_o), .irq_n_oe_o(irq_n_oe_o), .row_pointer_out_o(row_pointer_out_o),
  .end_of_message_flag_o(end_of_message_flag_o), .memory_full_flag_o(memory_full_flag_o),
  .powered_o(powered_o), .running_o(running_o), .play_mode_o(play_mode_o),
  .sample_tick_o(sample_tick_o));
`default_nettype wire

// [testbench/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o
);
  // Serial clock rests low between frames
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // High half of 5 clk and low half of 6 clk keep clear of the port's synchroniser
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk_i) ss_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i) mosi_o <= w[i];
      repeat (5) @(posedge clk_i);
      r[i] = miso_i;
      sclk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    ss_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // Released line must not keep the last bit
    repeat (10) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      fail_count++; \
      $display("wrong value %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module tb;
  // A 1024 kHz sample clock toggles 2048 times per 50,000 system cycles
  localparam int EXT_STEP = 2048;
  localparam int EXT_WRAP = 50000;
  logic clk_i = 1'b0, reset_i = 1'b1, ext_clk = 1'b0, row_end = 1'b0, marker = 1'b0;
  int ext_phase = 0;
  wire logic sclk, ss_n, mosi, miso, oe, irq_n, irq_oe, eflag, full, pwr, run, play, cue, tick;
  wire logic [10:0] ptr;
  wire logic miso_w = oe ? miso : ~miso; // Undriven line shows no stale bit
  wire logic irq_w = irq_oe ? irq_n : 1'b1; // Pull-up on the open-drain line
  logic [15:0] rx;
  int fail_count = 0, n_compared = 0, cycles = 0, ticks = 0, t0;
  voice_recorder_serial_command_port voice_recorder_serial_command_port_i (.clk_i(clk_i),
    .reset_i(reset_i), .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(oe), .ext_sample_clock_in_i(ext_clk), .row_end_i(row_end),
    .end_of_message_i(marker), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .row_pointer_out_o(ptr),
    .end_of_message_flag_o(eflag), .memory_full_flag_o(full), .powered_o(pwr),
    .running_o(run), .play_mode_o(play), .cue_mode_o(cue), .sample_tick_o(tick));
  spi_host_model spi_host_model_i (.clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk),
    .ss_n_o(ss_n), .mosi_o(mosi));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Sample clock by phase accumulation, one cycle of jitter; tick count and hang limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    ticks <= ticks + int'(tick);
    if (ext_phase + EXT_STEP >= EXT_WRAP) begin
      ext_phase <= ext_phase + EXT_STEP - EXT_WRAP;
      ext_clk <= ~ext_clk;
    end else begin
      ext_phase <= ext_phase + EXT_STEP;
    end
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic send(input logic [4:0] c, input logic [10:0] a);
    spi_host_model_i.xfer({c, a}, 16, rx);
  endtask
  // One-cycle event from the array side, then let it settle
  task automatic pulse(input logic at_row_end);
    @(posedge clk_i) begin
      if (at_row_end) begin
        row_end <= 1'b1;
      end else begin
        marker <= 1'b1;
      end
    end
    @(posedge clk_i) {row_end, marker} <= 2'b00;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK({pwr, run, ptr, eflag, full, irq_w}, 16'h0001)
    send(5'h04, 11'h000);
    `CHK({pwr, run, play, cue}, 4'h8)
    send(5'h1C, 11'h123);
    `CHK({pwr, run, play, cue, ptr}, {4'hE, 11'h123})
    send(5'h1E, 11'h055);
    `CHK(ptr, 11'h123)
    pulse(1'b0);
    `CHK({eflag, irq_w, run}, 3'b100)
    send(5'h06, 11'h000);
    `CHK(rx, {3'h0, 11'h123, 2'b10})
    `CHK({eflag, irq_w, run}, 3'b010)
    send(5'h14, 11'h7FF);
    `CHK({ptr, run, play}, {11'h4AF, 2'b10})
    pulse(1'b0);
    `CHK(run, 1'b1)
    pulse(1'b1);
    `CHK({full, run, irq_w}, 3'b100)
    spi_host_model_i.xfer(16'h1000, 10, rx);
    `CHK({pwr, full}, 2'b10)
    send(5'h1D, 11'h005);
    `CHK({pwr, run, play, cue, ptr}, {4'hF, 11'h005})
    send(5'h02, 11'h000);
    `CHK({pwr, run, play, cue}, 4'h0)
    t0 = ticks;
    repeat (2000) @(posedge clk_i);
    `CHK((ticks - t0) inside {[19:21]}, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
